// *** fspc_consts.svh ***
// fspc_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the controller
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
`define FSPC_CTRL_OFS 12'h0dc
`define FSPC_CTRL_IDX 8'h37
`define FSPC_MODE_OFS 12'h0e0
`define FSPC_BIT_IRQEN 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_REEN 4
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_WRT 2
`define FSPC_BIT_ERS 1
`define FSPC_BIT_SPE 0
`define FSPC_CTRL_RST 8'h00
`define FSPC_PAT_REEN 5'h11
`define FSPC_PAT_LOCK 5'h09
`define FSPC_PAT_WRT 5'h05
`define FSPC_PAT_ERS 5'h03
`define FSPC_PAT_FILL 5'h01
`define FSPC_ARM_CYC 3'h4
`define FSPC_LPM_CYC 3'h3
`define FSPC_PROG_MIN_US 3700
`define FSPC_PROG_MAX_US 4500
`define FSPC_CLK_MHZ 100
`define FSPC_Z_LOW 16'h0000
`define FSPC_Z_HIGH 16'h0003
`define FSPC_Z_EXT 16'h0002
`endif

// *** fspc_core_model.sv ***
// fspc_core_model.sv: processor core that issues store and load strobes
// assumes: runs on pclk beside fspc_ctrl; calls enter just after a pclk edge
`timescale 1ns/1ns
module fspc_core_model (
   input wire logic pclk,
   input wire logic cpu_halt,
   output logic store_strobe,
   output logic load_strobe
);
   initial begin
      store_strobe = 1'b0;
      load_strobe = 1'b0;
   end
   // one instruction lasts one cycle; a halted core issues nothing
   // and only strobes are issued, so no code fetch hits a busy section
   task automatic issue(input logic is_load);
      while (cpu_halt === 1'b1) @(posedge pclk);
      if (is_load) load_strobe <= 1'b1;
      else store_strobe <= 1'b1;
      @(posedge pclk);
      store_strobe <= 1'b0;
      load_strobe <= 1'b0;
   endtask : issue
endmodule : fspc_core_model

// *** fspc_ctrl.sv ***
// fspc_ctrl.sv: self-programming control register, arming window, sequencer
// assumes: apb master on pclk, core strobes on pclk, fuses from a static source
// limitation: boot lock protection modes are not enforced by this block
// the programming timer runs on pclk; PROG_CYCLES sets the span
`timescale 1ns/1ns
`include "fspc_consts.svh"
module fspc_ctrl #(
   parameter int PAGE_WORDS = 64,
   parameter int PAGE_BITS = 8,
   parameter int BOOT_PAGES = 32,
   parameter int NO_READ_WHILE_WRITE_SECTION_PAGE = 224,
   parameter int PROG_CYCLES = `FSPC_PROG_MIN_US * `FSPC_CLK_MHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_en,
   input wire logic eeprom_busy,
   input wire logic store_strobe,
   input wire logic load_strobe,
   input wire logic [15:0] z_pointer,
   input wire logic [15:0] reg_pair,
   input wire logic [15:0] pc_word,
   input wire logic [1:0] boot_size_fuses,
   input wire logic [7:0] lock_bits,
   input wire logic [7:0] low_fuse_byte,
   input wire logic [7:0] high_fuse_byte,
   input wire logic [7:0] extended_fuse_byte,
   output logic store_ready_irq,
   output logic cpu_halt,
   output logic section_busy_flag,
   output logic load_data_valid,
   output logic [7:0] load_data,
   output logic prog_start,
   output logic prog_erase,
   output logic [PAGE_BITS-1:0] prog_page,
   output logic [15:0] buffer_rdata
);
   localparam int PW = $clog2(PAGE_WORDS);
   typedef struct packed {
      logic [7:0] ctrl;
      fspc_pkg::fspc_st_t st;
      fspc_pkg::fspc_cmd_t cmd;
      logic [2:0] win;
      logic [31:0] tmr;
      logic filling;
      logic rww_busy;
      logic halt;
      logic irq;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic ld_v;
      logic [7:0] ld;
      logic pst;
      logic pers;
      logic [PAGE_BITS-1:0] page;
      logic [15:0] brd;
   } fspc_state_t;
   fspc_state_t s, next_s;
   logic [15:0] tbuf [PAGE_WORDS];
   logic clr_buf, fill_we;
   logic [PW-1:0] fill_idx;
   logic [PAGE_BITS-1:0] z_page, boot_start;

   // control write lands on the edge that completes the access
   logic wr_ctrl;
   assign wr_ctrl = psel && penable && s.ready && pwrite &&
                    paddr == `FSPC_CTRL_OFS;
   assign z_page = z_pointer[PW+1 +: PAGE_BITS];
   // boot section grows down from the top, size from fuses
   assign boot_start = PAGE_BITS'((1 << PAGE_BITS) -
                       (BOOT_PAGES >> boot_size_fuses));
   assign fill_idx = z_pointer[PW:1];

   always_comb begin
      logic [4:0] pat;
      logic from_boot;
      pat = pwdata[4:0];
      from_boot = pc_word[PW +: PAGE_BITS] >= boot_start;
      next_s = s;
      clr_buf = 1'b0;
      fill_we = 1'b0;
      next_s.ld_v = 1'b0;
      next_s.pst = 1'b0;
      next_s.ready = 1'b0;
      next_s.err = 1'b0;
      // two-cycle slave: answer one cycle after penable rises
      if (psel && penable && !s.ready) begin
         next_s.ready = 1'b1;
         next_s.err = paddr != `FSPC_CTRL_OFS && paddr != `FSPC_MODE_OFS;
         next_s.rdata = 32'h0;
         if (paddr == `FSPC_CTRL_OFS) begin
            // busy flag visible only in mode register, bits 6..5 zero
            next_s.rdata = {24'h0, s.ctrl & 8'h9f};
         end
         if (paddr == `FSPC_MODE_OFS) begin
            next_s.rdata = {30'h0, s.halt, s.rww_busy};
         end
      end
      case (s.st)
         fspc_pkg::FSPC_S_IDLE: begin
            if (wr_ctrl) begin
               next_s.ctrl[`FSPC_BIT_IRQEN] = pwdata[`FSPC_BIT_IRQEN];
               next_s.win = `FSPC_ARM_CYC;
               next_s.st = fspc_pkg::FSPC_S_ARMED;
               next_s.ctrl[4:0] = pat;
               case (pat)
                  `FSPC_PAT_FILL: next_s.cmd = fspc_pkg::FSPC_FILL;
                  `FSPC_PAT_ERS: next_s.cmd = fspc_pkg::FSPC_ERASE;
                  `FSPC_PAT_WRT: next_s.cmd = fspc_pkg::FSPC_WRITE;
                  `FSPC_PAT_LOCK: begin
                     next_s.cmd = fspc_pkg::FSPC_LOCK;
                     next_s.win = `FSPC_LPM_CYC;
                  end
                  `FSPC_PAT_REEN: begin
                     next_s.cmd = fspc_pkg::FSPC_REEN;
                     clr_buf = s.filling;
                     next_s.filling = 1'b0;
                  end
                  default: begin
                     next_s.ctrl[4:0] = s.ctrl[4:0];
                     next_s.st = fspc_pkg::FSPC_S_IDLE;
                  end
               endcase
            end
         end
         fspc_pkg::FSPC_S_ARMED: begin
            if (s.cmd == fspc_pkg::FSPC_LOCK && load_strobe) begin
               next_s.ld_v = 1'b1;
               // three fuse addresses pick a fuse byte, any other z reads
               // the lock bits; odd z other than the high byte lands there
               case (z_pointer)
                  `FSPC_Z_LOW: next_s.ld = low_fuse_byte;
                  `FSPC_Z_HIGH: next_s.ld = high_fuse_byte;
                  `FSPC_Z_EXT: next_s.ld = extended_fuse_byte;
                  default: next_s.ld = lock_bits;
               endcase
               next_s.ctrl[4:0] = 5'h00;
               next_s.st = fspc_pkg::FSPC_S_IDLE;
            end else if (store_strobe && from_boot) begin
               next_s.ctrl[4:0] = 5'h00;
               next_s.st = fspc_pkg::FSPC_S_IDLE;
               case (s.cmd)
                  fspc_pkg::FSPC_FILL: begin
                     fill_we = 1'b1;
                     next_s.filling = 1'b1;
                  end
                  fspc_pkg::FSPC_REEN: next_s.rww_busy = 1'b0;
                  fspc_pkg::FSPC_ERASE, fspc_pkg::FSPC_WRITE: begin
                     // any page, boot pages included; cmd bits held
                     next_s.ctrl[4:0] = s.ctrl[4:0];
                     next_s.st = fspc_pkg::FSPC_S_BUSY;
                     next_s.tmr = PROG_CYCLES;
                     next_s.pst = 1'b1;
                     next_s.pers = s.cmd == fspc_pkg::FSPC_ERASE;
                     next_s.page = z_page;
                     // halt only when the target sits in the no-rww part
                     next_s.halt = z_page >= PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE);
                     next_s.rww_busy = z_page < PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE);
                     if (s.cmd == fspc_pkg::FSPC_WRITE) next_s.filling = 1'b0;
                  end
                  default: ;
               endcase
            end else if (s.win == 3'h1) begin
               next_s.ctrl[4:0] = 5'h00;
               next_s.st = fspc_pkg::FSPC_S_IDLE;
            end else begin
               next_s.win = s.win - 3'h1;
            end
         end
         // programming timer; pclk stands in for the rc time base
         fspc_pkg::FSPC_S_BUSY: begin
            if (s.tmr == 32'h1) begin
               next_s.ctrl[4:0] = 5'h00;
               next_s.halt = 1'b0;
               next_s.st = fspc_pkg::FSPC_S_IDLE;
            end else begin
               next_s.tmr = s.tmr - 32'h1;
            end
         end
         default: next_s.st = fspc_pkg::FSPC_S_IDLE;
      endcase
      // irq level; blocked by eeprom write and any operation
      next_s.irq = next_s.ctrl[`FSPC_BIT_IRQEN] && global_irq_en &&
                   !next_s.ctrl[`FSPC_BIT_SPE] &&
                   !eeprom_busy && next_s.st != fspc_pkg::FSPC_S_BUSY;
      next_s.brd = tbuf[fill_idx];
   end

   // reset clears register and any armed command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // temporary page buffer, one write port per entry
   genvar gi;
   generate
      for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_buf
         always_ff @(posedge pclk) begin
            if (clk_en) begin
               if (clr_buf) tbuf[gi] <= 16'hffff;
               else if (fill_we && fill_idx == PW'(gi)) tbuf[gi] <= reg_pair;
            end
         end
      end
   endgenerate

   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign store_ready_irq = s.irq;
   assign cpu_halt = s.halt;
   assign section_busy_flag = s.rww_busy;
   assign load_data_valid = s.ld_v;
   assign load_data = s.ld;
   assign prog_start = s.pst;
   assign prog_erase = s.pers;
   assign prog_page = s.page;
   assign buffer_rdata = s.brd;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // cycles spent armed, for the window checks
   int unsigned arm_age;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) arm_age <= 0;
      else if (clk_en) arm_age <= (s.st == fspc_pkg::FSPC_S_ARMED) ?
                                  arm_age + 1 : 0;
   end
   arm_window_a: assert property (arm_age <= 4)
      else $error("arming window exceeded four cycles");
   reserved_zero_a: assert property (s.ready |-> prdata[6:5] == 2'b00)
      else $error("reserved bits read nonzero");
   irq_busy_a: assert property (s.st == fspc_pkg::FSPC_S_BUSY |->
      !store_ready_irq) else $error("irq during program");
   irq_spe_a: assert property (store_ready_irq |-> !s.ctrl[0])
      else $error("irq with enable set");
   busy_hold_a: assert property (s.st == fspc_pkg::FSPC_S_BUSY |->
      s.ctrl[0]) else $error("enable dropped during op");
   halt_no_read_while_write_section_a: assert property (prog_start && prog_page >=
      PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE) |-> cpu_halt) else $error("no halt");
   halt_rww_a: assert property (prog_start && prog_page <
      PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE) |-> !cpu_halt) else $error("halted");
   bad_pat_a: assert property (wr_ctrl && clk_en && s.st ==
      fspc_pkg::FSPC_S_IDLE && pwdata[4:0] == 5'h07 |=> s.ctrl[4:0] == 5'h00)
      else $error("illegal pattern acted");
   // a store fetched from the application section must not act
   logic from_b;
   assign from_b = pc_word[PW +: PAGE_BITS] >= boot_start;
   app_store_a: assert property (
      clk_en && s.st == fspc_pkg::FSPC_S_ARMED && !from_b &&
      store_strobe && s.win != 3'h1 |=>
      !prog_start && s.st == fspc_pkg::FSPC_S_ARMED)
      else $error("store from application acted");

   // reserved and busy positions of the control byte never hold a one
   ctrl_rsvd_a: assert property (
      s.ctrl[6:5] == 2'b00)
      else $error("reserved control bits set");
   // an eeprom write blocks the ready request from the next cycle on
   irq_eeprom_a: assert property (
      clk_en && eeprom_busy |=> !store_ready_irq)
      else $error("irq during eeprom write");

   // the halt is only ever raised by an operation on a no-rww page
   halt_only_busy_a: assert property (
      cpu_halt |-> s.st == fspc_pkg::FSPC_S_BUSY &&
      prog_page >= PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE))
      else $error("halt outside a no-rww operation");
   // programming a rww page marks that section unreadable
   rww_mark_a: assert property (
      prog_start && prog_page < PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE) |-> section_busy_flag)
      else $error("rww page programmed without busy flag");

   // the command bits stay visible while the operation starts
   start_pat_a: assert property (
      prog_start |-> s.ctrl[4:0] ==
      (prog_erase ? `FSPC_PAT_ERS : `FSPC_PAT_WRT))
      else $error("operation started under the wrong command");
   // every operation is timed for the full programming span
   start_time_a: assert property (
      prog_start |-> s.tmr == 32'(PROG_CYCLES))
      else $error("programming timer not loaded");
   // completion drops the command bits and releases the core
   busy_end_a: assert property (
      clk_en && s.st == fspc_pkg::FSPC_S_BUSY && s.tmr == 32'h1 |=>
      s.ctrl[4:0] == 5'h00 && !cpu_halt)
      else $error("operation end left command bits");

   // lock and fuse data only come out of a lock-read arming
   lock_src_a: assert property (
      load_data_valid |-> s.cmd == fspc_pkg::FSPC_LOCK)
      else $error("readback without lock-read command");
   // the lock-read arming is one cycle shorter than the store arming
   lock_window_a: assert property (
      s.st == fspc_pkg::FSPC_S_ARMED && s.cmd == fspc_pkg::FSPC_LOCK |->
      arm_age < 3)
      else $error("lock-read window exceeded three cycles");

   // an unused window lets every command bit go at once
   arm_expire_a: assert property (
      clk_en && s.st == fspc_pkg::FSPC_S_ARMED && s.win == 3'h1 &&
      !store_strobe && !load_strobe |=> s.ctrl[4:0] == 5'h00)
      else $error("command bits outlived the window");
   // a buffer fill completes the store and disarms at once
   fill_done_a: assert property (
      clk_en && s.st == fspc_pkg::FSPC_S_ARMED &&
      s.cmd == fspc_pkg::FSPC_FILL && store_strobe && from_b |=>
      s.filling && s.ctrl[4:0] == 5'h00)
      else $error("buffer fill did not complete");
   // a re-enable written mid-fill ends the fill
   reen_fill_a: assert property (
      clk_en && wr_ctrl && s.st == fspc_pkg::FSPC_S_IDLE &&
      pwdata[4:0] == `FSPC_PAT_REEN |=> !s.filling)
      else $error("fill survived a re-enable");

   // outside an arming or an operation no command bit is left over
   idle_clear_a: assert property (
      s.st == fspc_pkg::FSPC_S_IDLE |-> s.ctrl[4:0] == 5'h00)
      else $error("command bits set while idle");
   // an armed or running command always carries the enable bit
   armed_spe_a: assert property (
      s.st != fspc_pkg::FSPC_S_IDLE |-> s.ctrl[`FSPC_BIT_SPE])
      else $error("armed without enable bit");
   // main scenarios seen at least once
   cov_erase_c: cover property (prog_start && prog_erase);
   cov_write_c: cover property (prog_start && !prog_erase);
   cov_lock_c: cover property (load_data_valid);
   cov_irq_c: cover property (store_ready_irq);
   cov_reen_c: cover property (section_busy_flag ##1 !section_busy_flag);
endmodule : fspc_ctrl

// *** fspc_pkg.sv ***
// fspc_pkg.sv: types of the self-programming controller
// assumes: fspc_consts.svh alongside
package fspc_pkg;
   typedef enum logic [2:0] {
      FSPC_IDLE, FSPC_FILL, FSPC_ERASE, FSPC_WRITE, FSPC_REEN, FSPC_LOCK
   } fspc_cmd_t;
   typedef enum logic [1:0] {FSPC_S_IDLE, FSPC_S_ARMED, FSPC_S_BUSY} fspc_st_t;
endpackage : fspc_pkg

// *** fspc_tb_top.sv ***
// fspc_tb_top.sv: self-checking bench for the self-programming control
// assumes: fspc_ctrl and fspc_core_model are compiled before it
`timescale 1ns/1ns
module flash_self_programming_ctrl_tb_top;
   localparam int PROG = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic global_irq_en, eeprom_busy, store_strobe, load_strobe, cpu_halt;
   logic [15:0] z_pointer, reg_pair, pc_word, buffer_rdata, seed;
   logic [7:0] lock_bits, low_fuse_byte, high_fuse_byte, extended_fuse_byte;
   logic [7:0] load_data, prog_page, fz[4];
   logic [7:0] bad[3] = '{8'h07, 8'h0b, 8'h13};
   logic [1:0] zs[4] = '{2'h1, 2'h0, 2'h3, 2'h2};
   logic store_ready_irq, section_busy_flag, load_data_valid;
   logic prog_start, prog_erase;
   logic [15:0] exp_buf[64];
   int num_errors = 0;
   int n_compared = 0;
   int exp_prog[$];
   int got_prog[$];
   // short programming time keeps the run brief
   fspc_ctrl #(.PROG_CYCLES(PROG)) dut (
      .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .global_irq_en, .eeprom_busy,
      .store_strobe, .load_strobe, .z_pointer, .reg_pair, .pc_word,
      .boot_size_fuses(2'h0), .lock_bits, .low_fuse_byte, .high_fuse_byte,
      .extended_fuse_byte, .store_ready_irq, .cpu_halt, .section_busy_flag,
      .load_data_valid, .load_data, .prog_start, .prog_erase, .prog_page,
      .buffer_rdata
   );
   fspc_core_model core (.pclk, .cpu_halt, .store_strobe, .load_strobe);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // one apb transfer; pready and the answer are taken at the rising
   // edge that completes the access, then the request is released
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic op(input logic [7:0] cmd, input logic ld);
      apb(1'b1, 12'h0dc, {24'h0, cmd});
      core.issue(ld);
   endtask : op
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_pin
   task automatic give_verdict;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      #100000;
      num_errors++;
      give_verdict();
   end
   // every programming start is logged with its kind and page
   always @(negedge pclk) begin
      if (prog_start === 1'b1) got_prog.push_back({prog_erase, prog_page});
   end
   initial begin
      {presetn, psel, penable, pwrite, global_irq_en, eeprom_busy} = 6'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      z_pointer = 16'h0000;
      reg_pair = 16'h0000;
      pc_word = 16'h3f00; // boot section address
      seed = lfsr(16'h0039);
      {lock_bits, low_fuse_byte} = seed;
      seed = lfsr(seed);
      {high_fuse_byte, extended_fuse_byte} = seed;
      fz = '{lock_bits, low_fuse_byte, high_fuse_byte, extended_fuse_byte};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk_pin(err, 1'b1);
      // fill the two boundary words, odd z to show bit 0 is ignored
      for (int w = 0; w < 64; w += 63) begin
         seed = lfsr(seed);
         reg_pair <= seed;
         z_pointer <= {9'h0, 6'(w), 1'b1};
         op(8'h01, 1'b0);
         exp_buf[w] = seed;
         z_pointer <= {9'h0, 6'(w), 1'b0};
         repeat (3) @(negedge pclk);
         chk_reg(buffer_rdata, exp_buf[w]);
      end
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h0);
      pc_word <= 16'h0100; // application code may not store
      reg_pair <= ~seed;
      op(8'h01, 1'b0);
      pc_word <= 16'h3f00;
      repeat (3) @(negedge pclk);
      chk_reg(buffer_rdata, exp_buf[63]);
      op(8'h11, 1'b0);
      repeat (3) @(negedge pclk);
      chk_reg(buffer_rdata, 16'hffff);
      z_pointer <= {1'b0, 8'd230, 7'h0};
      foreach (bad[i]) begin
         op(bad[i], 1'b0);
         apb(1'b0, 12'h0dc, 32'h0);
         chk_reg(rd, 32'h0);
      end
      apb(1'b1, 12'h0dc, 32'h03);
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h0);
      core.issue(1'b0);
      // erase of a boot page in the halting section
      op(8'h03, 1'b0);
      exp_prog.push_back({1'b1, 8'd230});
      repeat (4) @(negedge pclk);
      chk_pin(cpu_halt, 1'b1);
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h03);
      repeat (PROG + 6) @(posedge pclk);
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h0);
      // write of a page in the section that keeps the core running
      z_pointer <= {1'b0, 8'd10, 7'h0};
      op(8'h05, 1'b0);
      exp_prog.push_back({1'b0, 8'd10});
      repeat (4) @(negedge pclk);
      chk_pin(cpu_halt, 1'b0);
      apb(1'b0, 12'h0e0, 32'h0);
      chk_reg(rd, 32'h1);
      repeat (PROG + 6) @(posedge pclk);
      op(8'h11, 1'b0);
      apb(1'b0, 12'h0e0, 32'h0);
      chk_reg(rd, 32'h0);
      foreach (zs[i]) begin
         z_pointer <= {14'h0, zs[i]};
         op(8'h09, 1'b1);
         for (int t = 0; t < 4 && load_data_valid !== 1'b1; t++)
            @(negedge pclk);
         chk_reg(load_data, fz[i]);
      end
      apb(1'b1, 12'h0dc, 32'he0);
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h80);
      global_irq_en <= 1'b1;
      repeat (3) @(negedge pclk);
      chk_pin(store_ready_irq, 1'b1);
      @(posedge pclk);
      eeprom_busy <= 1'b1;
      repeat (3) @(negedge pclk);
      chk_pin(store_ready_irq, 1'b0);
      @(posedge pclk);
      eeprom_busy <= 1'b0;
      z_pointer <= {1'b0, 8'd10, 7'h0};
      op(8'h83, 1'b0);
      exp_prog.push_back({1'b1, 8'd10});
      repeat (4) @(negedge pclk);
      chk_pin(store_ready_irq, 1'b0);
      repeat (PROG + 6) @(posedge pclk);
      // reset in mid-window drops the armed command
      apb(1'b1, 12'h0dc, 32'h03);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      core.issue(1'b0);
      apb(1'b0, 12'h0dc, 32'h0);
      chk_reg(rd, 32'h0);
      chk_reg(got_prog.size(), exp_prog.size());
      foreach (exp_prog[i]) chk_reg(got_prog[i], exp_prog[i]);
      give_verdict();
   end
endmodule : flash_self_programming_ctrl_tb_top
